// ---- sepa_host_model.sv ----
// sepa_host_model: spi host on the far side of the eeprom slave, mode 0
// assumes: clk_i is the 20 MHz bench clock; sck period is 8 clk (400 ns)
`timescale 1ns/1ps
module sepa_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  // sck stands low outside frames
  initial begin
    cs_n_o = 1'h1;
    sck_o = 1'h0;
    si_o = 1'h0;
  end
  task start_frame;
    @(posedge clk_i);
    cs_n_o <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o <= tx[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'h1;
      repeat (3) @(posedge clk_i);
      // so moves 3-4 clk after the fall, so sample late in the high phase
      @(negedge clk_i);
      rx[i] = so_i;
      @(posedge clk_i);
      sck_o <= 1'h0;
    end
  endtask
  task end_frame;
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'h1;
    repeat (8) @(posedge clk_i);
    si_o <= ~si_o;
  endtask
endmodule

// ---- sepa_pkg.sv ----
// sepa_pkg: constants, types and states of the serial eeprom access block
// assumes: one 20 MHz system clock; all users import the whole package
package sepa_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int TWC_MS = 5;
  localparam int TWC_CYC = TWC_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 20;

  // ****************************************
  // array and address
  // ****************************************
  localparam int MEM_DEPTH = 8192;
  localparam int MEM_AW = 13;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam int AMSB_BASE = 9;
  localparam logic [15:0] MASK_MAX = 16'h1fff;
  localparam logic [1:0] SIZE_MAX = 2'h3;
  localparam logic [1:0] SIZE_RST = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;

  // ****************************************
  // opcodes, low three bits; bit 3 is ignored
  // ****************************************
  localparam logic [3:0] OPC_HI = 4'h0;
  localparam logic [2:0] OPC_SET_WL = 3'h6;
  localparam logic [2:0] OPC_CLR_WL = 3'h4;
  localparam logic [2:0] OPC_RD_ST = 3'h5;
  localparam logic [2:0] OPC_WR_ST = 3'h1;
  localparam logic [2:0] OPC_READ = 3'h3;
  localparam logic [2:0] OPC_WRITE = 3'h2;

  // ****************************************
  // status byte
  // ****************************************
  localparam logic [7:0] STAT_BUSY_VAL = 8'hff;
  localparam int STAT_PIN_PROTECT_ENABLE_BIT_BIT = 7;
  localparam int STAT_BPHI_BIT = 3;
  localparam int STAT_BPLO_BIT = 2;

  // ****************************************
  // wishbone register map
  // ****************************************
  localparam logic [7:0] WB_SIZE_OFS = 8'h00;
  localparam logic [7:0] WB_STAT_OFS = 8'h04;

  typedef struct packed {
    logic pin_protect_enable_bit;
    logic bp_hi;
    logic bp_lo;
  } sepa_nv_s;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic guard_n;
  } sepa_pins_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR_HI, ST_ADDR_LO, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_IGN
  } sepa_state_e;

endpackage

// ---- sepa_top.sv ----
// sepa_top: command decoder, array, page buffer and protection of a serial eeprom slave
// assumes: spi pins and guard pin are asynchronous; sck is slow against clk_i (mode 0 or 3)
//
// Overview of operation
// - writes allowed when latch set, unguarded
// - guarded: array writes only, status write rejected
// - after address, ignore input, shift byte msb-first
// - continuous read increments address each byte
// - read address wraps to zero at top
// - never program block-protected locations
// - busy: only read-status instruction accepted
// - programming starts on select rising edge
// - status bit 0 shows write in progress
// - page write increments five low bits only
// - over 32 bytes wrap and overwrite
// - write latch cleared when cycle ends
// - latch clear: write instruction discarded
// - msb first, start on select fall
// - opcodes decoded with bit 3 ignored
// - hardware protect locks whole status register
// - status bit 1 shows write latch
`timescale 1ns/1ps
module sepa_top
  import sepa_pkg::*;
#(
  parameter int TWC_CYCLES = TWC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic guard_n_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic op_is(input logic [7:0] b, input logic [2:0] code);
    op_is = (b[7:4] == OPC_HI) && (b[2:0] == code);
  endfunction

  function automatic logic [15:0] cap_mask(input logic [1:0] sz);
    cap_mask = MASK_MAX >> (SIZE_MAX - sz);
  endfunction

  function automatic logic blk_prot(input logic [15:0] a, input sepa_nv_s nv, input logic [1:0] sz);
    logic top;
    logic nxt;
    top = a[AMSB_BASE + int'(sz)];
    nxt = a[AMSB_BASE - 1 + int'(sz)];
    unique case ({nv.bp_hi, nv.bp_lo})
      2'h0: blk_prot = 1'b0;
      2'h1: blk_prot = top & nxt;
      2'h2: blk_prot = top;
      2'h3: blk_prot = 1'b1;
    endcase
  endfunction

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  sepa_pins_s pin_raw;
  sepa_pins_s s1_r;
  sepa_pins_s s2_r;
  logic sck_d_r;
  logic cs_d_r;

  assign pin_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, guard_n: guard_n_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, guard_n: 1'b1};
      s2_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, guard_n: 1'b1};
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      sck_d_r <= s2_r.sck;
      cs_d_r <= s2_r.cs_n;
    end
  end

  wire sck_rise = s2_r.sck & ~sck_d_r;
  wire sck_fall = ~s2_r.sck & sck_d_r;
  wire cs_fall = ~s2_r.cs_n & cs_d_r;
  wire cs_rise = s2_r.cs_n & ~cs_d_r;

  // ****************************************
  // state and shared signals
  // ****************************************
  sepa_state_e state_r;
  sepa_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic got_r;
  logic is_wr_r;
  logic [15:0] addr_r;
  logic [7:0] out_r;
  logic [3:0] ocnt_r;
  logic so_r;
  logic so_oe_r;
  logic wen_r;
  logic busy_r;
  logic [TMR_W-1:0] tmr_r;
  logic st_pend_r;
  logic [7:0] st_data_r;
  logic [PAGE_W:0] pidx_r;
  logic [7:0] page_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pval_r;
  logic [7:0] mem_r [MEM_DEPTH];
  sepa_nv_s nv_r;
  logic [1:0] size_r;
  logic ack_r;
  logic [31:0] wb_dat_r;

  wire [7:0] in_byte = {shift_r[6:0], s2_r.si};
  wire active = ~s2_r.cs_n && state_r != ST_IDLE;
  wire byte_end = active && sck_rise && cnt_r == BIT_LAST;
  wire hw_prot = nv_r.pin_protect_enable_bit & ~s2_r.guard_n;
  wire [15:0] mask = cap_mask(size_r);
  wire [7:0] stat_byte = busy_r ? STAT_BUSY_VAL : {nv_r.pin_protect_enable_bit, 3'h0, nv_r.bp_hi, nv_r.bp_lo, wen_r, 1'b0};
  wire op_rdst = op_is(in_byte, OPC_RD_ST);
  wire load_rd = byte_end && state_r == ST_ADDR_LO && !is_wr_r;
  wire out_adv = active && sck_fall && (state_r == ST_RDATA || state_r == ST_SRD);
  wire rd_adv = out_adv && state_r == ST_RDATA && ocnt_r == BIT_LAST;
  wire [15:0] rd_next = (addr_r + 16'h1) & mask;
  wire [15:0] rd_addr = load_rd ? ({addr_r[15:8], in_byte} & mask) : rd_next;
  wire [7:0] mem_q = mem_r[rd_addr[MEM_AW-1:0]];
  wire wr_byte = byte_end && state_r == ST_WDATA;
  wire launch_arr = cs_rise && state_r == ST_WDATA && cnt_r == 4'h0 && got_r;
  wire launch_st = cs_rise && state_r == ST_SWR && cnt_r == 4'h0 && got_r && wen_r && !hw_prot;
  wire launch = launch_arr | launch_st;
  wire expire = busy_r && tmr_r == '0;
  wire [15:0] pg_addr = {addr_r[15:PAGE_W], pidx_r[PAGE_W-1:0]} & mask;
  wire prog_live = busy_r && !pidx_r[PAGE_W] && pval_r[pidx_r[PAGE_W-1:0]];
  wire prog_we = prog_live && !blk_prot(pg_addr, nv_r, size_r);

  // ****************************************
  // instruction decode
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OPC: begin
        if (busy_r && !op_rdst) begin
          state_nxt = ST_IGN;
        end else if (op_rdst) begin
          state_nxt = ST_SRD;
        end else if (op_is(in_byte, OPC_READ)) begin
          state_nxt = ST_ADDR_HI;
        end else if (op_is(in_byte, OPC_WRITE) && wen_r) begin
          state_nxt = ST_ADDR_HI;
        end else if (op_is(in_byte, OPC_WR_ST) && wen_r) begin
          state_nxt = ST_SWR;
        end else begin
          state_nxt = ST_IGN;
        end
      end
      ST_ADDR_HI: state_nxt = ST_ADDR_LO;
      ST_ADDR_LO: state_nxt = is_wr_r ? ST_WDATA : ST_RDATA;
      ST_IDLE, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_IGN: state_nxt = state_r;
    endcase
  end

  // every instruction is framed by a fresh select fall
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_rise) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      got_r <= 1'b0;
    end else if (cs_fall) begin
      state_r <= ST_OPC;
      cnt_r <= 4'h0;
      got_r <= 1'b0;
    end else if (active && sck_rise) begin
      cnt_r <= (cnt_r == BIT_LAST) ? 4'h0 : cnt_r + 4'h1;
      if (byte_end) begin
        state_r <= state_nxt;
        got_r <= got_r | state_r == ST_WDATA | state_r == ST_SWR;
      end
    end
  end

  // input sampled on rising sck, msb first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= 8'h0;
      is_wr_r <= 1'b0;
    end else if (active && sck_rise) begin
      shift_r <= in_byte;
      if (byte_end && state_r == ST_OPC) begin
        is_wr_r <= op_is(in_byte, OPC_WRITE);
      end
    end
  end

  // ****************************************
  // address counter and page buffer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r <= 16'h0;
    end else if (byte_end && state_r == ST_ADDR_HI) begin
      addr_r[15:8] <= in_byte;
    end else if (byte_end && state_r == ST_ADDR_LO) begin
      addr_r[7:0] <= in_byte;
    end else if (rd_adv) begin
      addr_r <= rd_next;
    end else if (wr_byte) begin
      addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + 5'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (cs_fall && !busy_r)) begin
      pval_r <= '0;
    end else if (wr_byte) begin
      pval_r[addr_r[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // later bytes at the same offset simply replace earlier ones
  always_ff @(posedge clk_i) begin
    if (wr_byte) begin
      page_r[addr_r[PAGE_W-1:0]] <= in_byte;
    end
  end

  // ****************************************
  // serial output, changed on falling sck
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r <= 8'h0;
      ocnt_r <= 4'h0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (s2_r.cs_n) begin
      so_oe_r <= 1'b0;
      ocnt_r <= 4'h0;
    end else if (load_rd) begin
      out_r <= mem_q;
      ocnt_r <= 4'h0;
    end else if (byte_end && state_r == ST_OPC && op_rdst) begin
      out_r <= stat_byte;
      ocnt_r <= 4'h0;
    end else if (out_adv) begin
      so_r <= out_r[7];
      so_oe_r <= 1'b1;
      if (ocnt_r == BIT_LAST) begin
        out_r <= (state_r == ST_RDATA) ? mem_q : stat_byte;
        ocnt_r <= 4'h0;
      end else begin
        out_r <= {out_r[6:0], 1'b0};
        ocnt_r <= ocnt_r + 4'h1;
      end
    end
  end

  // ****************************************
  // write latch, self-timed cycle, status
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || expire) begin
      wen_r <= 1'b0;
    end else if (byte_end && state_r == ST_OPC && !busy_r) begin
      if (op_is(in_byte, OPC_SET_WL)) begin
        wen_r <= 1'b1;
      end else if (op_is(in_byte, OPC_CLR_WL)) begin
        wen_r <= 1'b0;
      end
    end
  end

  // the cycle counts on clk_i, so a stopped sck cannot stretch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      tmr_r <= '0;
      st_pend_r <= 1'b0;
      st_data_r <= 8'h0;
      pidx_r <= '0;
    end else if (launch && !busy_r) begin
      busy_r <= 1'b1;
      tmr_r <= TMR_W'(TWC_CYCLES - 1);
      st_pend_r <= launch_st;
      st_data_r <= shift_r;
      pidx_r <= '0;
    end else if (busy_r) begin
      tmr_r <= tmr_r - 1'b1;
      busy_r <= !expire;
      if (!pidx_r[PAGE_W]) begin
        pidx_r <= pidx_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_r <= '0;
    end else if (expire && st_pend_r) begin
      nv_r.pin_protect_enable_bit <= st_data_r[STAT_PIN_PROTECT_ENABLE_BIT_BIT];
      nv_r.bp_hi <= st_data_r[STAT_BPHI_BIT];
      nv_r.bp_lo <= st_data_r[STAT_BPLO_BIT];
    end
  end

  // one page byte per clock at the start of the cycle
  always_ff @(posedge clk_i) begin
    if (prog_we) begin
      mem_r[pg_addr[MEM_AW-1:0]] <= page_r[pidx_r[PAGE_W-1:0]];
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  wire wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
  wire sel_size = wb_adr_i == WB_SIZE_OFS;
  wire sel_stat = wb_adr_i == WB_STAT_OFS;
  wire [31:0] wb_rd = sel_size ? {30'h0, size_r} : sel_stat ? {24'h0, stat_byte} : 32'h0;

  // changing size mid-transfer remaps the array; software does it idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_r <= 32'h0;
      size_r <= SIZE_RST;
    end else begin
      ack_r <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_r <= wb_rd;
      end
      if (wb_hit && wb_we_i && sel_size && wb_sel_i[0]) begin
        size_r <= wb_dat_i[1:0];
      end
    end
  end

  assign so_o = so_r;
  assign so_oe_o = so_oe_r;
  assign wb_dat_o = wb_dat_r;
  assign wb_ack_o = ack_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  so_release_a: assert property (cs_rise |=> !so_oe_o) else $error("so driven after select rise");
  busy_stat_a: assert property (busy_r |-> stat_byte == STAT_BUSY_VAL) else $error("status not all ones");
  latch_end_a: assert property ($fell(busy_r) |-> !wen_r) else $error("latch survived cycle");
  busy_ign_a: assert property (byte_end && state_r == ST_OPC && busy_r && !op_rdst |=> state_r == ST_IGN)
    else $error("command taken while busy");
  wr_discard_a: assert property (byte_end && state_r == ST_OPC && op_is(in_byte, OPC_WRITE) && !wen_r
    |=> state_r == ST_IGN) else $error("write taken without latch");
  st_guard_a: assert property ($rose(busy_r) && st_pend_r |-> $past(wen_r) && !$past(hw_prot))
    else $error("status write under protection");
  st_accept_a: assert property (launch_st && !busy_r |=> busy_r && st_pend_r)
    else $error("status write not started");
  launch_edge_a: assert property ($rose(busy_r) |-> $past(cs_rise)) else $error("cycle started off select rise");
  rd_wrap_a: assert property (rd_adv |=> addr_r == (($past(addr_r) + 16'h1) & $past(mask)))
    else $error("read address step wrong");
  page_step_a: assert property (wr_byte |=> addr_r[15:PAGE_W] == $past(addr_r[15:PAGE_W])
    && addr_r[PAGE_W-1:0] == $past(addr_r[PAGE_W-1:0]) + 5'h1) else $error("page step wrong");
  prot_skip_a: assert property (prog_we |-> !blk_prot(pg_addr, nv_r, size_r)) else $error("protected byte programmed");
  so_msb_a: assert property (out_adv && ocnt_r == 4'h0 |=> so_o == $past(out_r[7]) && so_oe_o)
    else $error("first bit not msb");

  rd_wrap_c: cover property (rd_adv && addr_r == mask);
  page_go_c: cover property (launch_arr && !busy_r);
  st_go_c: cover property (launch_st && !busy_r);
  poll_c: cover property (busy_r && state_r == ST_SRD && out_adv);

endmodule

// ---- test_sepa_top.sv ----
// test_sepa_top: self-checking bench of the serial eeprom slave
// assumes: sepa_host_model drives the spi pins; bench is wishbone master
`timescale 1ns/1ps
module test_sepa_top
  import sepa_pkg::*;
;
  logic clk_i, rst_i, guard_n_i, cs_n, sck, si, so_o, so_oe_o, so_line, last_so, oe_seen;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, b;
  logic [31:0] wb_dat_i, wb_dat_o, w;
  logic [3:0] wb_sel_i;
  logic [7:0] buf_tx [40];
  logic [7:0] buf_rx [40];
  int failures, checks;
  // rows: write address, read address, data, expected
  localparam logic [47:0] ROWS [4] = '{48'h0010_0010_a5a5, 48'he020_0020_3c3c, 48'h1fff_1fff_5a5a,
    48'h0000_0000_c3c3};
  always #25 clk_i = ~clk_i;
  // undriven so line shows the inverse of its last bit, never a friendly value
  assign so_line = (so_oe_o === 1'h1) ? so_o : ~last_so;
  always @(posedge clk_i) begin
    if (so_oe_o === 1'h1) begin
      last_so <= so_o;
      oe_seen <= 1'h1;
    end
  end
  sepa_top #(.TWC_CYCLES(2000)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .guard_n_i(guard_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  sepa_host_model i_host (.clk_i(clk_i), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  // ****************************************
  // tasks
  // ****************************************
  task end_of_test;
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    for (n = 0; n < 20 && wb_ack_o !== 1'h1; n++) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n == 20) begin
      failures++;
      end_of_test;
    end
  endtask
  task frame(input logic [7:0] op, input logic with_adr, input logic [15:0] adr, input int n);
    i_host.start_frame;
    i_host.xfer_byte(op, b);
    if (with_adr) begin
      i_host.xfer_byte(adr[15:8], b);
      i_host.xfer_byte(adr[7:0], b);
    end
    for (int k = 0; k < n; k++) i_host.xfer_byte(buf_tx[k], buf_rx[k]);
    i_host.end_frame;
  endtask
  task rd_status(output logic [7:0] st);
    frame(8'h05, 1'h0, 16'h0, 1);
    st = buf_rx[0];
  endtask
  task wait_ready;
    int n;
    for (n = 0; n < 50; n++) begin
      rd_status(b);
      if (b[0] === 1'h0) break;
    end
    if (n == 50) begin
      failures++;
      end_of_test;
    end
  endtask
  task wr_byte(input logic [15:0] adr, input logic [7:0] d);
    frame(8'h06, 1'h0, 16'h0, 0);
    buf_tx[0] = d;
    frame(8'h02, 1'h1, adr, 1);
    wait_ready;
  endtask
  task rd_byte(input logic [15:0] adr, output logic [7:0] d);
    frame(8'h03, 1'h1, adr, 1);
    d = buf_rx[0];
  endtask
  // latch is cleared afterwards as a rejected write may leave it set
  task wr_status(input logic [7:0] d);
    frame(8'h06, 1'h0, 16'h0, 0);
    buf_tx[0] = d;
    frame(8'h01, 1'h0, 16'h0, 1);
    wait_ready;
    frame(8'h04, 1'h0, 16'h0, 0);
    rd_status(b);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    guard_n_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    last_so = 1'h0;
    oe_seen = 1'h0;
    failures = 0;
    checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    cmp_byte({7'h0, so_oe_o}, 8'h0);
    wb(1'h0, 8'h00, 32'h0, w);
    cmp_word(w, 32'h3);
    wb(1'h0, 8'h08, 32'h0, w);
    cmp_word(w, 32'h0);
    wb(1'h1, 8'h00, 32'h0, w);
    wb(1'h0, 8'h00, 32'h0, w);
    cmp_word(w, 32'h0);
    wb(1'h1, 8'h00, 32'h3, w);
    for (int i = 0; i < 4; i++) begin
      wr_byte(ROWS[i][47:32], ROWS[i][15:8]);
      rd_byte(ROWS[i][31:16], b);
      cmp_byte(b, ROWS[i][7:0]);
    end
    frame(8'h03, 1'h1, 16'h1fff, 2);
    cmp_byte(buf_rx[0], 8'h5a);
    cmp_byte(buf_rx[1], 8'hc3);
    frame(8'h0e, 1'h0, 16'h0, 0);
    rd_status(b);
    cmp_byte(b, 8'h02);
    frame(8'h04, 1'h0, 16'h0, 0);
    rd_status(b);
    cmp_byte(b, 8'h00);
    buf_tx[0] = 8'h77;
    frame(8'h02, 1'h1, 16'h0010, 1);
    rd_status(b);
    cmp_byte(b, 8'h00);
    rd_byte(16'h0010, b);
    cmp_byte(b, 8'ha5);
    frame(8'h06, 1'h0, 16'h0, 0);
    buf_tx[0] = 8'h11;
    frame(8'h02, 1'h1, 16'h0030, 1);
    frame(8'h0d, 1'h0, 16'h0, 1);
    cmp_byte(buf_rx[0], 8'hff);
    wb(1'h0, 8'h04, 32'h0, w);
    cmp_word(w, 32'hff);
    oe_seen = 1'h0;
    frame(8'h03, 1'h1, 16'h0010, 1);
    cmp_byte({7'h0, oe_seen}, 8'h0);
    buf_tx[0] = 8'hee;
    frame(8'h02, 1'h1, 16'h0010, 1);
    wait_ready;
    rd_status(b);
    cmp_byte(b, 8'h00);
    rd_byte(16'h0010, b);
    cmp_byte(b, 8'ha5);
    rd_byte(16'h0030, b);
    cmp_byte(b, 8'h11);
    frame(8'h06, 1'h0, 16'h0, 0);
    for (int k = 0; k < 34; k++) buf_tx[k] = 8'h80 + 8'(k);
    frame(8'h02, 1'h1, 16'h005e, 34);
    wait_ready;
    frame(8'h03, 1'h1, 16'h0040, 32);
    for (int j = 0; j < 32; j++) cmp_byte(buf_rx[j], 8'h82 + 8'(j));
    wr_status(8'h84);
    cmp_byte(b, 8'h84);
    guard_n_i <= 1'h0;
    wr_byte(16'h0010, 8'h66);
    rd_byte(16'h0010, b);
    cmp_byte(b, 8'h66);
    wr_byte(16'h1fff, 8'h77);
    rd_byte(16'h1fff, b);
    cmp_byte(b, 8'h5a);
    wr_status(8'h00);
    cmp_byte(b, 8'h84);
    guard_n_i <= 1'h1;
    wr_status(8'h00);
    cmp_byte(b, 8'h00);
    end_of_test;
  end
endmodule
